/* dv/host_term.sv */
module host_term
    import prog_cmd_pkg::*;
#(
    parameter int unsigned BIT_CYC = 16
) (
    input wire logic core_clk_in,
    input wire logic txd_in,
    output logic rxd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    initial rxd_out = 1'b1;
    // ==========================================================
    // sender: start, eight data bits lsb first, stop level given
    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk_in);
            rxd_out <= f[i];
            repeat (BIT_CYC - 1) @(posedge core_clk_in);
        end
        @(posedge core_clk_in);
        rxd_out <= 1'b1;
    endtask
    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++) begin
            send_byte(s[i], 1'b1);
        end
        send_byte(CH_ENTER, 1'b1);
    endtask
    // ==========================================================
    // receiver: mid-bit sampling; a bad stop drops the character
    always begin : rx_proc
        logic [7:0] b;
        @(negedge txd_in);
        repeat (BIT_CYC / 2) @(posedge core_clk_in);
        if (txd_in === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge core_clk_in);
                b[i] = txd_in;
            end
            repeat (BIT_CYC) @(posedge core_clk_in);
            if (txd_in === 1'b1) begin
                got_q.push_back(b);
            end
        end
    end
endmodule // host_term

/* dv/prog_cmd_chk.sv */
module prog_cmd_chk
    import prog_cmd_pkg::*;
#(
    parameter int unsigned BIT_CYC = 16
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire prog_cmd_pkg::reg_req_s reg_req_in,
    input wire logic [15:0] reg_rdata_out,
    input wire prog_cmd_pkg::machine_state_s mach_in,
    input wire logic [7:0] panel_prog_in,
    input wire logic rxd_in,
    input wire logic txd_out,
    input wire logic [7:0] sel_prog_out,
    input wire logic remote_active_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // helper logic
    logic stat_rd;
    logic run_q;
    logic armed_q;
    assign stat_rd = reg_req_in.rd && reg_req_in.addr == ADDR_STAT_WORD;
    // armed once a run starts under a remote choice; a choice made
    // mid-run must not restore at that run's end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            run_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            run_q <= mach_in.running;
            armed_q <= remote_active_out
                & (armed_q | (mach_in.running & ~run_q));
        end
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // ==========================================================
    // assertions
    a_stat_switches: assert property (
        stat_rd && $stable(mach_in) |=> reg_rdata_out[6:0] == $past(mach_in))
        else $error("status low bits wrong");
    a_stat_bit7_zero: assert property (
        stat_rd |=> reg_rdata_out[7] == 1'b0)
        else $error("status bit 7 set");
    a_stat_panel: assert property (
        stat_rd && $stable(panel_prog_in)
        |=> reg_rdata_out[15:8] == $past(panel_prog_in))
        else $error("status panel field wrong");
    a_restore_end: assert property (
        armed_q && run_q && !mach_in.running
        |-> ##[1:3] !remote_active_out)
        else $error("no restore after remote run");
    a_sel_tracks: assert property (
        $past(arst_n_in) && !remote_active_out && !$past(remote_active_out)
        |-> sel_prog_out == $past(panel_prog_in))
        else $error("selection not tracking panel");
    a_remote_hold: assert property (
        remote_active_out && $past(remote_active_out) && $changed(sel_prog_out)
        |-> ##[0:40] $fell(txd_out))
        else $error("remote selection changed silently");
    a_assign_reply: assert property (
        $rose(remote_active_out) |-> ##[0:40] $fell(txd_out))
        else $error("no reply after assignment");
    a_start_bit: assert property (
        $fell(txd_out) |-> !txd_out [*8])
        else $error("start bit too short");
    c_stat_rd: cover property (stat_rd);
    c_assign: cover property ($rose(remote_active_out));
    c_restore: cover property ($fell(remote_active_out));
endmodule // prog_cmd_chk

bind serial_program_select_cmd prog_cmd_chk #(.BIT_CYC(BIT_CYC)) u_chk (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out),
    .mach_in(mach_in),
    .panel_prog_in(panel_prog_in),
    .rxd_in(rxd_in),
    .txd_out(txd_out),
    .sel_prog_out(sel_prog_out),
    .remote_active_out(remote_active_out),
    .irq_out(irq_out)
);

/* dv/serial_program_select_cmd_tb.sv */
module serial_program_select_cmd_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import prog_cmd_pkg::*;
    localparam int unsigned BC = 16;
    logic clk, arst_n, rxd, txd, remote, irq;
    reg_req_s req;
    machine_state_s mach;
    logic [15:0] rdata;
    logic [7:0] panel, sel;
    int bad_count = 0;
    int n_tests = 0;
    serial_program_select_cmd #(.BIT_CYC(BC)) DUT (
        .core_clk_in(clk), .arst_n_in(arst_n), .reg_req_in(req),
        .reg_rdata_out(rdata), .mach_in(mach), .panel_prog_in(panel),
        .rxd_in(rxd), .txd_out(txd), .sel_prog_out(sel),
        .remote_active_out(remote), .irq_out(irq));
    host_term #(.BIT_CYC(BC)) host (
        .core_clk_in(clk), .txd_in(txd), .rxd_out(rxd));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask
    // an empty string expects silence after the command
    task automatic expect_reply(input string s);
        int k;
        k = 0;
        while (host.got_q.size() < s.len() && k < 4000) begin
            @(posedge clk);
            k++;
        end
        tick(12 * BC);
        check(host.got_q.size(), s.len());
        for (int i = 0; i < s.len() && i < host.got_q.size(); i++) begin
            check(host.got_q[i], s[i]);
        end
        host.got_q.delete();
    endtask
    task automatic cmd(input string c, input string r);
        host.send_str(c);
        expect_reply(r);
    endtask
    function automatic string rep(input string b);
        return {"#", b, "\015"};
    endfunction
    // ==========================================================
    // scenarios
    task automatic t_disabled;
        logic [15:0] v;
        reg_rd(ADDR_CTRL, v);
        check(v, 16'h0000);
        reg_rd(4'hF, v);
        check(v, 16'h0000);
        cmd("P5", "");
        check(sel, 8'h01);
        reg_rd(ADDR_IRQ_STAT, v);
        check(v, 16'h0004);
        check(irq, 1'b0);
        reg_wr(ADDR_IRQ_EN, 16'h0004);
        tick(3);
        check(irq, 1'b1);
        reg_wr(ADDR_IRQ_CLR, 16'h0004);
        tick(3);
        check(irq, 1'b0);
    endtask
    task automatic t_assign;
        string bad[3] = '{"P256", "P", "?X"};
        logic [15:0] v;
        reg_wr(ADDR_CTRL, 16'h0001);
        cmd("?P", rep("1"));
        cmd("P2", rep("2"));
        check(remote, 1'b1);
        reg_rd(ADDR_SEL, v);
        check(v, 16'h0102);
        cmd("?P", rep("2"));
        @(posedge clk);
        panel <= 8'h07;
        tick(4);
        check(sel, 8'h02);
        cmd("P255", rep("255"));
        for (int i = 0; i < 3; i++) begin
            cmd(bad[i], "");
            check(sel, 8'hFF);
        end
        @(posedge clk);
        mach.running <= 1'b1;
        tick(8);
        check(sel, 8'hFF);
        @(posedge clk);
        mach.running <= 1'b0;
        tick(4);
        check(sel, 8'h07);
        check(remote, 1'b0);
        cmd("?P", rep("7"));
        reg_rd(ADDR_IRQ_STAT, v);
        check(v, 16'h0017);
    endtask
    task automatic t_status;
        logic [6:0] m[2] = '{7'h7F, 7'h2A};
        logic [7:0] p[2] = '{8'hA5, 8'h3C};
        logic [15:0] w, v;
        string s;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            mach <= m[i];
            panel <= p[i];
            tick(3);
            w = {p[i], 1'b0, m[i]};
            s = rep("0000");
            for (int j = 0; j < 4; j++) begin
                v = w >> (12 - 4 * j);
                v = v & 16'h000F;
                s.putc(j + 1, v < 10 ? CH_ZERO + v[7:0] : CH_HEX_A + v[7:0]);
            end
            cmd("?S", s);
            reg_rd(ADDR_STAT_WORD, v);
            check(v, w);
        end
    endtask
    task automatic t_frame;
        logic [15:0] v;
        host.send_byte(CH_QUERY, 1'b0);
        tick(4 * BC);
        reg_rd(ADDR_IRQ_STAT, v);
        check(v & 16'h0008, 16'h0008);
        check(sel, 8'h3C);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        arst_n = 1'b0;
        req = '0;
        mach = '0;
        panel = 8'h01;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_disabled();
        t_assign();
        t_status();
        t_frame();
        end_of_test();
    end
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        $display("Error at %0t: timeout", $time);
        end_of_test();
    end
endmodule // serial_program_select_cmd_tb

/* hw/prog_cmd_pkg.sv */
package prog_cmd_pkg;
    // ======================================================
    // timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned BAUD_RATE = 115200;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int unsigned DATA_BITS = 8;
    // ======================================================
    // characters of the command language
    localparam logic [7:0] CH_ENTER = 8'h0D;
    localparam logic [7:0] CH_QUERY = 8'h3F;
    localparam logic [7:0] CH_PROG = 8'h50;
    localparam logic [7:0] CH_STAT = 8'h53;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_HEX_A = 8'h37;
    localparam int unsigned PROG_DIGITS = 3;
    localparam int unsigned REPLY_MAX = 6;
    // ======================================================
    // register map, 16-bit data
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SEL = 4'h1;
    localparam logic [3:0] ADDR_STAT_WORD = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
    localparam logic CTRL_RST = 1'b0;
    localparam int unsigned IRQ_W = 5;
    localparam int unsigned IRQ_REPLY = 0;
    localparam int unsigned IRQ_ASSIGN = 1;
    localparam int unsigned IRQ_DROP = 2;
    localparam int unsigned IRQ_FRAME = 3;
    localparam int unsigned IRQ_RESTORE = 4;
    localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } reg_req_s;
    typedef struct packed {
        logic wait_start;
        logic homing;
        logic motor_busy;
        logic emergency;
        logic running;
        logic start_sw;
        logic teach_sw;
    } machine_state_s;
endpackage

/* hw/serial_port.sv */
module serial_port #(
    parameter int unsigned BIT_CYC = prog_cmd_pkg::BIT_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic rxd_in,
    output logic txd_out,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic rx_frame_err_out,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_data_in,
    output logic tx_ready_out
);
    import prog_cmd_pkg::*;
    localparam int CW = $clog2(BIT_CYC + 1);
    localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
    localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);
    // ======================================================
    // receiver: 8 data bits, no parity, one stop bit
    logic rx_busy_q;
    logic [CW-1:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    wire rx_tick = rx_busy_q && (rx_cnt_q == '0);
    wire rx_stop = rx_tick && (rx_bit_q == 4'h9);
    // start edge is rechecked at mid-bit to reject glitches
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_busy_q <= 1'b0;
            rx_cnt_q <= '0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
        end else if (!rx_busy_q) begin
            rx_busy_q <= !rxd_in;
            rx_cnt_q <= HALF;
            rx_bit_q <= 4'h0;
        end else if (rx_tick) begin
            rx_cnt_q <= FULL;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0 && rxd_in) rx_busy_q <= 1'b0;
            if (rx_bit_q != 4'h0 && rx_bit_q != 4'h9)
                rx_sh_q <= {rxd_in, rx_sh_q[7:1]};
            if (rx_stop) rx_busy_q <= 1'b0;
        end else begin
            rx_cnt_q <= rx_cnt_q - CW'(1);
        end
    end
    // received byte and framing error, one-cycle pulses
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_valid_out <= 1'b0;
            rx_frame_err_out <= 1'b0;
            rx_data_out <= 8'h00;
        end else begin
            rx_valid_out <= rx_stop && rxd_in;
            rx_frame_err_out <= rx_stop && !rxd_in;
            if (rx_stop) rx_data_out <= rx_sh_q;
        end
    end
    // ======================================================
    // transmitter: start bit, data lsb first, stop bit
    logic [9:0] tx_sh_q;
    logic [3:0] tx_left_q;
    logic [CW-1:0] tx_cnt_q;
    wire tx_take = tx_valid_in && tx_ready_out;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_sh_q <= 10'h3FF;
            tx_left_q <= 4'h0;
            tx_cnt_q <= '0;
            txd_out <= 1'b1;
            tx_ready_out <= 1'b1;
        end else if (tx_take) begin
            tx_sh_q <= {1'b1, tx_data_in, 1'b0};
            tx_left_q <= 4'hA;
            tx_cnt_q <= '0;
            tx_ready_out <= 1'b0;
        end else if (tx_left_q != 4'h0) begin
            if (tx_cnt_q == '0) begin
                txd_out <= tx_sh_q[0];
                tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                tx_left_q <= tx_left_q - 4'h1;
                tx_cnt_q <= FULL;
            end else begin
                tx_cnt_q <= tx_cnt_q - CW'(1);
            end
        end else if (tx_cnt_q != '0) begin
            tx_cnt_q <= tx_cnt_q - CW'(1);
        end else begin
            tx_ready_out <= 1'b1;
        end
    end
endmodule // serial_port

/* hw/serial_program_select_cmd.sv */
// Notes on behaviour
// - remote program choice over serial works only while remote enable is set.
// - link runs 115200 baud, 8 data bits, no parity, one stop bit.
// - "?P" plus enter replies '#' and the selected program number.
// - "P<n>" plus enter selects program n and replies '#' and n.
// - start runs the remotely selected program, not the panel one.
// - when the remote program finishes, selection returns to the panel number.
// - "?S" plus enter replies with the current status word.
// - status bits 0..3: teach, start switch, running, emergency.
// - status bits 4..6: motor busy, homing, waiting for start press.
// - status bits 8..15 carry the front panel program number.
//
// The register offsets and strobed register access are this design's own decisions.
module serial_program_select_cmd #(
    parameter int unsigned BIT_CYC = prog_cmd_pkg::BIT_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire prog_cmd_pkg::reg_req_s reg_req_in,
    output logic [15:0] reg_rdata_out,
    input wire prog_cmd_pkg::machine_state_s mach_in,
    input wire logic [7:0] panel_prog_in,
    input wire logic rxd_in,
    output logic txd_out,
    output logic [7:0] sel_prog_out,
    output logic remote_active_out,
    output logic irq_out
);
    import prog_cmd_pkg::*;

    // parser states
    typedef enum logic [2:0] {
        PS_IDLE,
        PS_QUERY,
        PS_QUERY_P,
        PS_QUERY_S,
        PS_ASSIGN,
        PS_DISCARD
    } parse_e;

    // ======================================================
    // serial line
    // the port frames bits; here only bytes
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_frame_err;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;

    serial_port #(
        .BIT_CYC(BIT_CYC)
    ) u_port (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .rxd_in(rxd_in),
        .txd_out(txd_out),
        .rx_valid_out(rx_valid),
        .rx_data_out(rx_data),
        .rx_frame_err_out(rx_frame_err),
        .tx_valid_in(tx_valid),
        .tx_data_in(tx_data),
        .tx_ready_out(tx_ready)
    );

    // ======================================================
    // registers
    logic remote_en_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic irq_q;
    logic [15:0] rdata_q;

    // command parser
    parse_e state_q;
    parse_e state_d;
    logic [9:0] acc_q;
    logic [9:0] acc_d;
    logic [1:0] ndig_q;
    logic [1:0] ndig_d;

    // program selection
    logic [7:0] sel_q;
    logic remote_q;
    logic remote_run_q;
    logic running_prev_q;

    // reply image and sender
    logic [7:0] reply_q [REPLY_MAX];
    logic [7:0] reply_d [REPLY_MAX];
    logic [2:0] reply_len_q;
    logic [2:0] reply_len_d;
    logic [2:0] reply_idx_q;
    logic sending_q;

    // ======================================================
    // status word, bit 7 held at zero
    // sampled live at the enter
    wire [15:0] stat_word = {panel_prog_in, 1'b0,
        mach_in.wait_start, mach_in.homing, mach_in.motor_busy,
        mach_in.emergency, mach_in.running,
        mach_in.start_sw, mach_in.teach_sw};

    // ======================================================
    // character classes
    // line feed is plain text, not an end
    wire is_enter = rx_data == CH_ENTER;
    wire is_digit = rx_data >= CH_ZERO && rx_data <= CH_NINE;
    wire [3:0] digit = 4'(rx_data - CH_ZERO);
    // a number needs a digit and fits a byte
    wire acc_ok = ndig_q != 2'd0 && acc_q <= 10'd255;

    // ======================================================
    // command recognition; a disabled link parses nothing
    wire live = rx_valid && remote_en_q;

    // commands end on their enter
    wire end_qp = live && is_enter && state_q == PS_QUERY_P;
    wire end_qs = live && is_enter && state_q == PS_QUERY_S;
    wire end_as = live && is_enter && state_q == PS_ASSIGN
        && acc_ok;
    wire any_cmd = end_qp || end_qs || end_as;

    // a reply still in flight makes a new command unanswerable,
    // so it is dropped whole rather than half served
    wire accept = any_cmd && !sending_q;
    wire do_assign = end_as && !sending_q;

    // drops raise the drop event
    wire bad_end = live && is_enter && state_q != PS_IDLE
        && !any_cmd;
    wire off_end = rx_valid && !remote_en_q && is_enter;
    wire dropped = bad_end || off_end || (any_cmd && sending_q);

    // parser next state
    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        ndig_d = ndig_q;
        // switching off abandons a half line
        if (!remote_en_q) begin
            state_d = PS_IDLE;
        end else if (rx_valid) begin
            case (state_q)
                PS_IDLE: begin
                    acc_d = 10'd0;
                    ndig_d = 2'd0;
                    if (rx_data == CH_QUERY) state_d = PS_QUERY;
                    else if (rx_data == CH_PROG) state_d = PS_ASSIGN;
                    else if (!is_enter) state_d = PS_DISCARD;
                end
                PS_QUERY: begin
                    if (rx_data == CH_PROG) state_d = PS_QUERY_P;
                    else if (rx_data == CH_STAT) state_d = PS_QUERY_S;
                    else if (is_enter) state_d = PS_IDLE;
                    else state_d = PS_DISCARD;
                end
                PS_QUERY_P, PS_QUERY_S: begin
                    state_d = is_enter ? PS_IDLE : PS_DISCARD;
                end
                PS_ASSIGN: begin
                    if (is_enter) begin
                        state_d = PS_IDLE;
                    end else if (is_digit && ndig_q < 2'(PROG_DIGITS)) begin
                        acc_d = 10'(acc_q * 10'd10 + {6'd0, digit});
                        ndig_d = ndig_q + 2'd1;
                    end else begin
                        // extra digit or stray text
                        state_d = PS_DISCARD;
                    end
                end
                PS_DISCARD: begin
                    if (is_enter) state_d = PS_IDLE;
                end
                default: state_d = PS_IDLE;
            endcase
        end
    end

    // parser state
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= PS_IDLE;
            acc_q <= 10'd0;
            ndig_q <= 2'd0;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            ndig_q <= ndig_d;
        end
    end

    // ======================================================
    // selected program: remote choice holds until its run ends
    wire remote_done = remote_run_q && running_prev_q
        && !mach_in.running;
    wire run_begins = remote_q && !running_prev_q && mach_in.running;
    // new_prog holds until the next line
    wire [7:0] new_prog = acc_q[7:0];

    // a run going at assignment time does not count;
    // only a run it started ends the choice
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sel_q <= 8'h00;
            remote_q <= 1'b0;
            remote_run_q <= 1'b0;
            running_prev_q <= 1'b0;
        end else begin
            running_prev_q <= mach_in.running;
            if (do_assign) begin
                sel_q <= new_prog;
                remote_q <= 1'b1;
                remote_run_q <= 1'b0;
            end else if (remote_done) begin
                sel_q <= panel_prog_in;
                remote_q <= 1'b0;
                remote_run_q <= 1'b0;
            end else if (!remote_q) begin
                sel_q <= panel_prog_in;
            end else if (run_begins) begin
                remote_run_q <= 1'b1;
            end
        end
    end

    // ======================================================
    // reply text: '#', number in decimal or status in hex, enter
    // upper-case hex digit
    function automatic logic [7:0] hex_ch(input logic [3:0] n);
        hex_ch = (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_HEX_A + {4'h0, n};
    endfunction

    // decimal, no leading zeros
    wire [7:0] num = do_assign ? new_prog : sel_q;
    wire [3:0] d_hun = 4'(num / 8'd100);
    wire [3:0] d_ten = 4'((num / 8'd10) % 8'd10);
    wire [3:0] d_one = 4'(num % 8'd10);

    // rebuilt each cycle, kept on accept
    always_comb begin
        for (int i = 0; i < REPLY_MAX; i++) reply_d[i] = CH_ENTER;
        reply_d[0] = CH_HASH;
        reply_len_d = 3'd2;
        if (end_qs) begin
            for (int i = 0; i < 4; i++)
                reply_d[1 + i] = hex_ch(stat_word[15 - 4 * i -: 4]);
            reply_len_d = 3'd6;
        end else if (d_hun != 4'h0) begin
            reply_d[1] = CH_ZERO + {4'h0, d_hun};
            reply_d[2] = CH_ZERO + {4'h0, d_ten};
            reply_d[3] = CH_ZERO + {4'h0, d_one};
            reply_len_d = 3'd5;
        end else if (d_ten != 4'h0) begin
            reply_d[1] = CH_ZERO + {4'h0, d_ten};
            reply_d[2] = CH_ZERO + {4'h0, d_one};
            reply_len_d = 3'd4;
        end else begin
            reply_d[1] = CH_ZERO + {4'h0, d_one};
            reply_len_d = 3'd3;
        end
    end

    // ======================================================
    // reply sender, one character per serial frame
    assign tx_valid = sending_q;
    assign tx_data = reply_q[reply_idx_q];
    wire tx_take = tx_valid && tx_ready;
    wire tx_last = reply_idx_q == reply_len_q - 3'd1;

    // ready falls as it takes, so no byte goes twice

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < REPLY_MAX; i++) reply_q[i] <= 8'h00;
            reply_len_q <= 3'd0;
            reply_idx_q <= 3'd0;
            sending_q <= 1'b0;
        end else if (accept) begin
            reply_q <= reply_d;
            reply_len_q <= reply_len_d;
            reply_idx_q <= 3'd0;
            sending_q <= 1'b1;
        end else if (tx_take) begin
            reply_idx_q <= reply_idx_q + 3'd1;
            sending_q <= !tx_last;
        end
    end

    // ======================================================
    // register decode
    wire wr_ctrl = reg_req_in.wr && reg_req_in.addr == ADDR_CTRL;
    wire wr_en = reg_req_in.wr && reg_req_in.addr == ADDR_IRQ_EN;
    wire wr_clr = reg_req_in.wr && reg_req_in.addr == ADDR_IRQ_CLR;
    wire [IRQ_W-1:0] clr_mask =
        wr_clr ? reg_req_in.wdata[IRQ_W-1:0] : '0;

    // one event source per status bit
    wire [IRQ_W-1:0] irq_evt;
    assign irq_evt[IRQ_REPLY] = accept;
    assign irq_evt[IRQ_ASSIGN] = do_assign;
    assign irq_evt[IRQ_DROP] = dropped;
    assign irq_evt[IRQ_FRAME] = rx_frame_err;
    assign irq_evt[IRQ_RESTORE] = remote_done;
    // new event beats a clear in the same cycle
    wire [IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~clr_mask) | irq_evt;

    // read mux; clear register and holes read as zero
    // looked at only under a read strobe
    logic [15:0] rd_mux;
    always_comb begin
        case (reg_req_in.addr)
            ADDR_CTRL: rd_mux = {15'h0000, remote_en_q};
            ADDR_SEL: rd_mux = {7'h00, remote_q, sel_q};
            ADDR_STAT_WORD: rd_mux = stat_word;
            ADDR_IRQ_STAT: rd_mux = {11'h000, irq_stat_q};
            ADDR_IRQ_EN: rd_mux = {11'h000, irq_en_q};
            default: rd_mux = 16'h0000;
        endcase
    end

    // control, interrupt and read data registers
    // irq lags status one cycle, from a flop
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            remote_en_q <= CTRL_RST;
            irq_stat_q <= IRQ_RST;
            irq_en_q <= IRQ_RST;
            irq_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            if (wr_ctrl) remote_en_q <= reg_req_in.wdata[0];
            if (wr_en) irq_en_q <= reg_req_in.wdata[IRQ_W-1:0];
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_q & irq_en_q);
            rdata_q <= reg_req_in.rd ? rd_mux : 16'h0000;
        end
    end

    // ======================================================
    // outputs straight from flops
    assign reg_rdata_out = rdata_q;
    assign sel_prog_out = sel_q;
    assign remote_active_out = remote_q;
    assign irq_out = irq_q;
endmodule // serial_program_select_cmd
